// *** bench/testbench.sv ***
// self-checking bench for the pwm timer
`timescale 1ns/1ps
`default_nettype none
`include "timer_defs.vh"
module testbench;
  localparam int P = 16;
  logic core_clk = 0, rst = 1, wr = 0, rd = 0, wait_mode = 0, ext = 0;
  logic [3:0] addr = 0, pin_out, pin_oe, c;
  logic [15:0] wdata = 0, rdata, w;
  logic force_in, irq, wake;
  integer errors = 0, compares = 0, seed = 32'hB47E, ones;
  timer_a_unit uut (.core_clk(core_clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .wait_mode(wait_mode),
    .ext_count_clock_pin(ext), .chan_pin_in(4'h0), .chan_pin_out(pin_out),
    .chan_pin_oe(pin_oe), .ext_pin_force_input(force_in), .irq(irq),
    .wake(wake));
  initial
    forever #20 core_clk = ~core_clk;
  task automatic final_report;
    if (errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input [15:0] got, input [15:0] exp);
    compares += 1;
    if (got !== exp)
    begin
      errors += 1;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input [3:0] a, input [15:0] v);
    @(posedge core_clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input [3:0] a, input [15:0] m, input [15:0] e);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 chk(rdata & m, e);
  endtask
  function automatic [15:0] duty(input [7:0] ctl, input [15:0] v);
    if (!ctl[`C_TOV])
      duty = ctl[`C_MAX] ? 2 * P : 0;
    else
      duty = 2 * (v + 1);
  endfunction
  task automatic pwm(input [3:0] a, input [15:0] v, input [3:0] ch,
    input [15:0] e);
    wreg(a, v);
    repeat (2 * P) @(posedge core_clk);
    ones = 0;
    repeat (2 * P)
    begin
      @(posedge core_clk);
      ones += pin_out[ch];
    end
    chk(ones, e);
  endtask
  initial
  begin
    repeat (20000) @(posedge core_clk);
    errors += 1;
    final_report;
  end
  initial
  begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    rreg(`A_STATUS, 16'hFFFF, {8'h00, `RST_STATUS});
    rreg(`A_MOD, 16'hFFFF, `RST_MOD);
    rreg(4'h3, 16'hFFFF, 16'h0000);
    wreg(`A_STATUS, 16'h0030);
    rreg(`A_COUNT, 16'hFFFF, 16'h0000);
    rreg(`A_STATUS, 16'h0010, 16'h0000);
    wreg(`A_MOD, P - 1);
    wreg(`A_STATUS, 16'h0000);
    repeat (40) @(posedge core_clk);
    rreg(`A_STATUS, 16'h0080, 16'h0080);
    chk(irq, 0);
    wreg(`A_STATUS, 16'h00C0);
    repeat (3) @(posedge core_clk);
    chk(irq, 1);
    wait_mode <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk(wake, 1);
    rreg(`A_STATUS, 16'hFFFF, 16'h0000);
    wreg(`A_MOD, 16'h0007);
    wait_mode <= 1'b0;
    rreg(`A_MOD, 16'hFFFF, P - 1);
    rreg(`A_STATUS, 16'h0080, 16'h0080);
    wreg(`A_STATUS, 16'h0000);
    repeat (2) @(posedge core_clk);
    chk(irq, 0);
    for (c = 0; c < 4; c++)
    begin
      w = 1 + {$random(seed)} % 14;
      wreg(`A_CMP0 + c, w);
      pwm(`A_CSC0 + c, 16'h005A, c, duty(8'h5A, w));
      chk(pin_oe[c], 1);
      rreg(`A_CSC0 + c, 16'h0080, 16'h0080);
      chk(irq, 1);
      pwm(`A_CSC0 + c, 16'h0018, c, duty(8'h18, w));
      pwm(`A_CSC0 + c, 16'h0019, c, duty(8'h19, w));
      wreg(`A_CSC0 + c, 16'h0000);
    end
    for (c = 0; c < 4; c += 2)
    begin
      wreg(`A_CMP0 + c, 16'h0003);
      pwm(`A_CSC0 + c, 16'h003A, c, duty(8'h3A, 3));
      chk(pin_oe[c + 1], 0);
      pwm(`A_CMP0 + c + 1, 16'h000E, c, duty(8'h3A, 14));
      pwm(`A_CMP0 + c, 16'h0001, c, duty(8'h3A, 1));
      wreg(`A_CSC0 + c, 16'h0000);
    end
    wreg(`A_STATUS, 16'h0037);
    wreg(`A_STATUS, 16'h0007);
    repeat (5)
    begin
      repeat (3) @(posedge core_clk);
      ext <= 1'b1;
      repeat (3) @(posedge core_clk);
      ext <= 1'b0;
    end
    repeat (4) @(posedge core_clk);
    chk(force_in, 1);
    rreg(`A_COUNT, 16'hFFFF, 16'h0005);
    wreg(`A_STATUS, 16'h0000);
    repeat (3) @(posedge core_clk);
    chk(force_in, 0);
    final_report;
  end
endmodule // testbench
`default_nettype wire

// *** bench/timer_checker_sva.sv ***
// port assertions for the pwm timer
`timescale 1ns/1ps
`default_nettype none
`include "timer_defs.vh"
module timer_checker (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] rdata,
  input wire logic wait_mode,
  input wire logic [3:0] chan_pin_out,
  input wire logic [3:0] chan_pin_oe,
  input wire logic ext_pin_force_input,
  input wire logic irq,
  input wire logic wake
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  wire logic wr_ok = wr && !wait_mode;
  wire logic st_wr = wr_ok && addr == `A_STATUS;
  rst_clear_a: assert property ($fell(rst) |-> !irq && !wake)
    else $error("request high after reset");
  wait_read_a: assert property (rd && wait_mode |=> rdata == 16'h0000)
    else $error("read reached registers in wait");
  wake_set_a: assert property (irq && wait_mode ##1 irq && wait_mode |-> wake)
    else $error("no wake on request");
  wake_clear_a: assert property (!wait_mode |=> !wake)
    else $error("wake outside wait");
  ext_force_a: assert property (
    st_wr && wdata[2:0] == `PS_EXT |-> ##[1:2] ext_pin_force_input)
    else $error("clock pin not forced input");
  ext_free_a: assert property (
    st_wr && wdata[2:0] != `PS_EXT |-> ##[1:2] !ext_pin_force_input)
    else $error("clock pin still forced");
  pair01_free_a: assert property (
    wr_ok && addr == `A_CSC0 && wdata[`C_MSB] |-> ##[1:3] !chan_pin_oe[1])
    else $error("pin 1 kept while linked");
  pair23_free_a: assert property (
    wr_ok && addr == 4'h6 && wdata[`C_MSB] |-> ##[1:3] !chan_pin_oe[3])
    else $error("pin 3 kept while linked");
  max_duty_a: assert property (
    wr_ok && addr == `A_CSC0 && wdata[5:0] == 6'h19 |-> ##[1:4] chan_pin_out[0])
    else $error("max duty not high");
  cover property (wake);
  cover property (ext_pin_force_input);
  cover property (st_wr && wdata[`S_OIE]);
endmodule // timer_checker
bind timer_a_unit timer_checker chk_i (.core_clk(core_clk), .rst(rst),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .wait_mode(wait_mode), .chan_pin_out(chan_pin_out),
  .chan_pin_oe(chan_pin_oe), .ext_pin_force_input(ext_pin_force_input),
  .irq(irq), .wake(wake));
`default_nettype wire

// *** common/timer_defs.vh ***
// constants for the four-channel pwm timer
`ifndef TIMER_DEFS_VH
`define TIMER_DEFS_VH
`define A_STATUS 4'h0
`define A_MOD 4'h1
`define A_COUNT 4'h2
`define A_CSC0 4'h4
`define A_CMP0 4'h8
`define A_PORTCTL 4'hC
`define S_PS_LSB 0
`define S_RST 4
`define S_HALT 5
`define S_OIE 6
`define S_OVF 7
`define C_MAX 0
`define C_TOV 1
`define C_ELA 2
`define C_ELB 3
`define C_MSA 4
`define C_MSB 5
`define C_IE 6
`define C_FLG 7
`define PS_EXT 3'h7
`define RST_STATUS 8'h20
`define RST_MOD 16'hFFFF
`define CH_COUNT 4
`endif

// *** core/timer_a_unit.v ***
// four-channel timer with buffered and unbuffered pwm
//
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "timer_defs.vh"
// Summary of operation
// - channel 0 buffered bit links channels 0 and 1, output on pin 0
// - channel 0 compare rules first; channel 1 write takes over next period
// - at each overflow, last-written compare of the pair takes control
// - while linked, channel 1 control unused and pin 1 freed
// - channel 2 buffered bit links 2 and 3 the same way
// - buffered select beats single select on channels 0 and 2
// - mode field 0:1 unbuffered, 1:0 buffered compare or pwm
// - edge/level 1:0 clears output on compare, 1:1 sets it
// - toggle-on-overflow clear means no toggle, giving 0 percent duty with clear on compare
// - max duty set with toggle clear holds output at 100 percent
// - counter steps on clock; overflow flag set after rollover to zero
// - overflow request only when enable and flag both set
// - channel flag set on compare only (edge bits make the pin an output), request gated by enable
// - wait mode keeps running, blocks register access, irq wakes
// - prescale select all ones picks external clock pin
// - external clock pin forced to input while selected
// - each channel pin compare output when edge/level or mode bits set (buffered select counts on even pins only), except the odd pin of a linked pair
// - unbuffered compare value takes effect at once
// - toggle-on-overflow toggles output when counter rolls over from modulo to zero
// - at modulo, flag set and count restarts at zero
// - counter reset bit clears counter and prescaler, self-clears
module timer_a_unit #(
  parameter CW = 16
) (
  input wire core_clk,
  input wire rst,
  input wire [3:0] addr,
  input wire [15:0] wdata,
  input wire wr,
  input wire rd,
  output reg [15:0] rdata,
  input wire wait_mode,
  input wire ext_count_clock_pin,
  input wire [3:0] chan_pin_in,
  output reg [3:0] chan_pin_out,
  output reg [3:0] chan_pin_oe,
  output reg ext_pin_force_input,
  output reg irq,
  output reg wake
);
  reg [CW-1:0] count_reg;
  reg [CW-1:0] mod_reg;
  reg [7:0] status_reg;
  reg [6:0] presc_reg;
  reg ext_d_reg;
  reg [7:0] csc_reg [0:3];
  reg [CW-1:0] cmp_reg [0:3];
  reg [3:0] pin_in_d_reg;
  reg [3:0] out_reg;
  reg [1:0] sel_reg;
  reg [1:0] pend_reg;
  reg ovf_rd_reg;
  reg [3:0] flg_rd_reg;
  wire acc = ~wait_mode;
  wire wr_ok = wr & acc;
  wire rd_ok = rd & acc;
  wire [2:0] ps = status_reg[2:0];
  wire halted = status_reg[`S_HALT];
  wire ext_sel = (ps == `PS_EXT);
  reg tick;
  always @*
  begin
    case (ps)
      3'h0: tick = 1'b1;
      3'h7: tick = ext_count_clock_pin & ~ext_d_reg;
      default: tick = (presc_reg & ((7'h01 << (ps - 3'h1)) * 7'h02 - 7'h01))
        == ((7'h01 << (ps - 3'h1)) * 7'h02 - 7'h01);
    endcase
  end
  wire step = tick & ~halted;
  wire at_mod = (count_reg == mod_reg);
  wire ovf = step & at_mod;
  wire rst_cnt = wr_ok & (addr == `A_STATUS) & wdata[`S_RST];
  // pair bookkeeping
  wire [1:0] linked;
  assign linked[0] = csc_reg[0][`C_MSB];
  assign linked[1] = csc_reg[2][`C_MSB];
  wire [3:0] cmp_wr;
  wire [3:0] match;
  wire [3:0] active;
  genvar g;
  generate
    for (g = 0; g < `CH_COUNT; g = g + 1)
    begin : chan
      assign cmp_wr[g] = wr_ok & (addr == `A_CMP0 + g);
      assign match[g] = step & (count_reg == cmp_reg[g]);
      // even channel uses own selected register, odd is disabled when linked
      if (g % 2 == 0)
      begin : even
        wire [CW-1:0] bcmp = sel_reg[g/2] ? cmp_reg[g+1] : cmp_reg[g];
        wire bmatch = step & (count_reg == bcmp);
        wire [7:0] c = csc_reg[g];
        wire outmode = c[`C_MSB] | c[`C_MSA] | c[`C_ELB] | c[`C_ELA];
        assign active[g] = outmode;
        always @(posedge core_clk)
        begin
          if (rst)
            out_reg[g] <= 1'b0;
          else if (c[`C_MAX] & ~c[`C_TOV] & (c[`C_MSB] | c[`C_MSA]))
            out_reg[g] <= 1'b1;
          else if (c[`C_TOV] & ovf)
            out_reg[g] <= ~out_reg[g];
          else if ((c[`C_MSB] ? bmatch : match[g]) & c[`C_ELB])
            out_reg[g] <= c[`C_ELA];
          else if ((c[`C_MSB] ? bmatch : match[g]) & ~c[`C_ELB] & c[`C_ELA])
            out_reg[g] <= ~out_reg[g];
        end
      end
      else
      begin : odd
        wire [7:0] c = csc_reg[g];
        assign active[g] = ~linked[g/2] & (c[`C_MSA] | c[`C_ELB] | c[`C_ELA]);
        always @(posedge core_clk)
        begin
          if (rst)
            out_reg[g] <= 1'b0;
          else if (linked[g/2])
            out_reg[g] <= 1'b0;
          else if (c[`C_MAX] & ~c[`C_TOV] & c[`C_MSA])
            out_reg[g] <= 1'b1;
          else if (c[`C_TOV] & ovf)
            out_reg[g] <= ~out_reg[g];
          else if (match[g] & c[`C_ELB])
            out_reg[g] <= c[`C_ELA];
          else if (match[g] & ~c[`C_ELB] & c[`C_ELA])
            out_reg[g] <= ~out_reg[g];
        end
      end
    end
  endgenerate
  // channel events: compare when output; no capture edges, as an input channel has edge bits clear
  reg [3:0] ev;
  integer i;
  always @*
  begin
    ev = 4'h0;
    for (i = 0; i < 4; i = i + 1)
    begin
      if (active[i])
        ev[i] = (i % 2 == 0 && linked[i/2]) ?
          (step & (count_reg == (sel_reg[i/2] ? cmp_reg[i+1] : cmp_reg[i])))
          : match[i];
      else if (~((i % 2 == 1) && linked[i/2]))
        ev[i] = (csc_reg[i][`C_ELA] & chan_pin_in[i] & ~pin_in_d_reg[i]) |
          (csc_reg[i][`C_ELB] & ~chan_pin_in[i] & pin_in_d_reg[i]);
    end
  end
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      count_reg <= {CW{1'b0}};
      presc_reg <= 7'h00;
      ext_d_reg <= 1'b0;
      pin_in_d_reg <= 4'h0;
    end
    else
    begin
      ext_d_reg <= ext_count_clock_pin;
      pin_in_d_reg <= chan_pin_in;
      if (rst_cnt)
      begin
        count_reg <= {CW{1'b0}};
        presc_reg <= 7'h00;
      end
      else
      begin
        if (~halted)
          presc_reg <= presc_reg + 7'h01;
        if (step)
          count_reg <= at_mod ? {CW{1'b0}} : count_reg + 1'b1;
      end
    end
  end
  // buffered selection switches on overflow to last-written register
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : pair
      always @(posedge core_clk)
      begin
        if (rst | ~linked[g])
        begin
          sel_reg[g] <= 1'b0;
          pend_reg[g] <= 1'b0;
        end
        else
        begin
          if (cmp_wr[2*g+1])
            pend_reg[g] <= 1'b1;
          else if (cmp_wr[2*g])
            pend_reg[g] <= 1'b0;
          if (ovf)
            sel_reg[g] <= cmp_wr[2*g+1] ? 1'b1 :
              (cmp_wr[2*g] ? 1'b0 : pend_reg[g]);
        end
      end
    end
  endgenerate
  // registers
  integer k;
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      status_reg <= `RST_STATUS;
      mod_reg <= `RST_MOD;
      ovf_rd_reg <= 1'b0;
      flg_rd_reg <= 4'h0;
      for (k = 0; k < 4; k = k + 1)
      begin
        csc_reg[k] <= 8'h00;
        cmp_reg[k] <= {CW{1'b0}};
      end
    end
    else
    begin
      if (rd_ok & (addr == `A_STATUS))
        ovf_rd_reg <= status_reg[`S_OVF];
      if (wr_ok & (addr == `A_STATUS))
      begin
        status_reg[6:0] <= {wdata[6:5], 1'b0, wdata[3:0]};
        if (ovf_rd_reg & ~wdata[`S_OVF])
          status_reg[`S_OVF] <= 1'b0;
        ovf_rd_reg <= 1'b0;
      end
      if (ovf)
        status_reg[`S_OVF] <= 1'b1;
      if (wr_ok & (addr == `A_MOD))
        mod_reg <= wdata[CW-1:0];
      for (k = 0; k < 4; k = k + 1)
      begin
        if (rd_ok & (addr == `A_CSC0 + k))
          flg_rd_reg[k] <= csc_reg[k][`C_FLG];
        if (wr_ok & (addr == `A_CSC0 + k))
        begin
          csc_reg[k][6:0] <= wdata[6:0];
          if (flg_rd_reg[k] & ~wdata[`C_FLG])
            csc_reg[k][`C_FLG] <= 1'b0;
          flg_rd_reg[k] <= 1'b0;
        end
        if (cmp_wr[k])
          cmp_reg[k] <= wdata[CW-1:0];
        if (ev[k])
          csc_reg[k][`C_FLG] <= 1'b1;
      end
    end
  end
  reg irq_now;
  integer j;
  always @*
  begin
    irq_now = status_reg[`S_OVF] & status_reg[`S_OIE];
    for (j = 0; j < 4; j = j + 1)
      if (~((j % 2 == 1) && linked[j/2]))
        irq_now = irq_now | (csc_reg[j][`C_FLG] & csc_reg[j][`C_IE]);
  end
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      rdata <= 16'h0000;
      irq <= 1'b0;
      wake <= 1'b0;
      chan_pin_out <= 4'h0;
      chan_pin_oe <= 4'h0;
      ext_pin_force_input <= 1'b0;
    end
    else
    begin
      irq <= irq_now;
      wake <= irq_now & wait_mode;
      chan_pin_out <= out_reg;
      chan_pin_oe <= active;
      ext_pin_force_input <= ext_sel;
      rdata <= 16'h0000;
      if (rd_ok)
      begin
        case (addr)
          `A_STATUS: rdata <= {8'h00, status_reg};
          `A_MOD: rdata <= mod_reg;
          `A_COUNT: rdata <= count_reg;
          `A_CSC0, `A_CSC0 + 4'h1, `A_CSC0 + 4'h2, `A_CSC0 + 4'h3:
            rdata <= {8'h00, csc_reg[addr[1:0]]};
          `A_CMP0, `A_CMP0 + 4'h1, `A_CMP0 + 4'h2, `A_CMP0 + 4'h3:
            rdata <= cmp_reg[addr[1:0]];
          default: rdata <= 16'h0000;
        endcase
      end
    end
  end
endmodule // timer_a_unit
`default_nettype wire
